// [include/obcd_pkg.sv]
// Purpose: shared constants and types of the option byte config decoder
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   option bytes stand only behind the programming-mode window
package obcd_pkg;

	// register byte addresses
	localparam logic [7:0] OBCD_ADDR_OPT0   = 8'h00;
	localparam logic [7:0] OBCD_ADDR_OPT1   = 8'h04;
	localparam logic [7:0] OBCD_ADDR_CTRL   = 8'h08;
	localparam logic [7:0] OBCD_ADDR_STATUS = 8'h0c;

	// option byte 0 fields
	localparam int OBCD_B0_HALT_WDG = 7;
	localparam int OBCD_B0_WDG_KIND = 6;
	localparam int OBCD_B0_VD_HI    = 4;
	localparam int OBCD_B0_VD_LO    = 3;
	localparam int OBCD_B0_RDP      = 0;

	// option byte 1 fields
	localparam int OBCD_B1_RST_CYC  = 6;
	localparam int OBCD_B1_OSC_HI   = 5;
	localparam int OBCD_B1_OSC_LO   = 4;
	localparam int OBCD_B1_RNG_HI   = 3;
	localparam int OBCD_B1_RNG_LO   = 1;
	localparam int OBCD_B1_DBL_OFF  = 0;

	// ctrl and status bits
	localparam int OBCD_CTRL_ERASE   = 0;
	localparam int OBCD_ST_PROG      = 0;
	localparam int OBCD_ST_BUSY      = 1;
	localparam int OBCD_ST_DBL_BAD   = 2;
	localparam int OBCD_ST_RDP       = 3;
	localparam int OBCD_ST_LOADED    = 4;

	// erased and shipped contents
	localparam logic [7:0] OBCD_ERASED     = 8'hff;
	localparam logic [7:0] OBCD_SHIP_OPT0  = 8'hff;
	localparam logic [7:0] OBCD_SHIP_OPT1  = 8'hef;

	// reset phase lengths in cpu cycles
	localparam logic [12:0] OBCD_RST_LONG  = 13'h1000;
	localparam logic [12:0] OBCD_RST_SHORT = 13'h0100;

	// oscillator encodings
	localparam logic [1:0] OBCD_OSC_RESONATOR = 2'h0;
	localparam logic [1:0] OBCD_OSC_RESERVED  = 2'h1;
	localparam logic [1:0] OBCD_OSC_INT_RC    = 2'h2;
	localparam logic [1:0] OBCD_OSC_EXTERNAL  = 2'h3;
	localparam logic [2:0] OBCD_RANGE_MP      = 3'h1;

	typedef enum logic [1:0] {
		OBCD_VD_HIGH   = 2'h0,
		OBCD_VD_MEDIUM = 2'h1,
		OBCD_VD_LOW    = 2'h2,
		OBCD_VD_OFF    = 2'h3
	} obcd_vd_t;

	typedef enum logic [1:0] {
		OBCD_IDLE,
		OBCD_MEM_ERASE,
		OBCD_OPT_ERASE
	} obcd_erase_t;

	typedef struct packed {
		logic        halt_watchdog_reset_opt;
		logic        watchdog_always_on;
		logic        low_voltage_detector;
		logic        aux_voltage_detector;
		obcd_vd_t    voltage_detect_level;
		logic        readout_protect;
		logic [12:0] reset_cycle_count;
		logic [1:0]  osc_source_type;
		logic [2:0]  osc_range_select;
		logic        clock_doubler_en;
		logic        clock_doubler_bad;
	} obcd_cfg_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} obcd_apb_req_t;

endpackage

// [hdl/obcd_option_decoder.sv]
// Purpose: option byte store and decoder with apb access
// Assumes: prog_mode is an asynchronous pin; erase handshake on pclk
// Notes:   decoded settings are frozen at the first edge after reset
//
// Contract
// - option bytes reachable only while programming mode is active.
// - erased option byte reads all ones.
// - byte0 bit7 set makes halt with running watchdog cause reset.
// - byte0 bit6 clear means watchdog always on from reset.
// - byte0 bits 4:3 pick detector threshold or switch detectors off.
// - byte0 bit0 clear blocks code extraction and flash writes.
// - erasing protected option bytes erases user memory first.
// - parts ship with internal rc oscillator selected.
// - byte1 bit6 picks 4096 or 256 cycle reset phase.
// - byte1 bits 5:4 decode the clock source type.
// - byte1 bit0 clear enables doubler, only with mp range, not rc.
`timescale 1ns/1ns
`default_nettype none

module obcd_option_decoder (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              prog_mode,
	input  wire logic              user_mem_erase_done,
	output logic                   user_mem_erase_req,
	output logic                   flash_read_block,
	output logic                   flash_write_block,
	output obcd_pkg::obcd_cfg_t    cfg
);

	typedef struct packed {
		logic [7:0]            opt0;
		logic [7:0]            opt1;
		logic                  prog_meta;
		logic                  prog_sync;
		logic                  loaded;
		logic [7:0]            snap0;
		logic [7:0]            snap1;
		obcd_pkg::obcd_erase_t erase;
		logic [31:0]           rdata;
		logic                  err;
	} obcd_state_t;

	obcd_state_t         st_ff;
	obcd_state_t         nxt_st;
	obcd_pkg::obcd_apb_req_t req;
	logic                setup;
	logic                access;
	logic                opt_addr;
	logic                known;
	logic                busy;
	obcd_pkg::obcd_cfg_t dec;

	assign req.psel    = psel;
	assign req.penable = penable;
	assign req.pwrite  = pwrite;
	assign req.paddr   = paddr;
	assign req.pwdata  = pwdata;

	assign setup    = req.psel && !req.penable;
	assign access   = req.psel && req.penable;
	assign busy     = st_ff.erase != obcd_pkg::OBCD_IDLE;
	assign opt_addr = req.paddr == obcd_pkg::OBCD_ADDR_OPT0 ||
		req.paddr == obcd_pkg::OBCD_ADDR_OPT1;
	assign known    = opt_addr ||
		req.paddr == obcd_pkg::OBCD_ADDR_CTRL ||
		req.paddr == obcd_pkg::OBCD_ADDR_STATUS;

	// decode the frozen snapshot, never the live bytes
	always_comb begin
		dec = '0;
		dec.halt_watchdog_reset_opt =
			st_ff.snap0[obcd_pkg::OBCD_B0_HALT_WDG];
		dec.watchdog_always_on =
			!st_ff.snap0[obcd_pkg::OBCD_B0_WDG_KIND];
		dec.voltage_detect_level = obcd_pkg::obcd_vd_t'(
			st_ff.snap0[obcd_pkg::OBCD_B0_VD_HI:
			obcd_pkg::OBCD_B0_VD_LO]);
		dec.low_voltage_detector =
			dec.voltage_detect_level != obcd_pkg::OBCD_VD_OFF;
		dec.aux_voltage_detector = dec.low_voltage_detector;
		dec.readout_protect =
			!st_ff.snap0[obcd_pkg::OBCD_B0_RDP];
		dec.reset_cycle_count =
			st_ff.snap1[obcd_pkg::OBCD_B1_RST_CYC] ?
			obcd_pkg::OBCD_RST_SHORT : obcd_pkg::OBCD_RST_LONG;
		dec.osc_source_type = st_ff.snap1[obcd_pkg::OBCD_B1_OSC_HI:
			obcd_pkg::OBCD_B1_OSC_LO];
		dec.osc_range_select = st_ff.snap1[obcd_pkg::OBCD_B1_RNG_HI:
			obcd_pkg::OBCD_B1_RNG_LO];
		// an illegal doubler setting is refused, not passed on
		dec.clock_doubler_bad =
			!st_ff.snap1[obcd_pkg::OBCD_B1_DBL_OFF] &&
			(dec.osc_range_select != obcd_pkg::OBCD_RANGE_MP ||
			dec.osc_source_type == obcd_pkg::OBCD_OSC_INT_RC);
		dec.clock_doubler_en =
			!st_ff.snap1[obcd_pkg::OBCD_B1_DBL_OFF] &&
			!dec.clock_doubler_bad;
	end

	always_comb begin
		nxt_st = st_ff;
		// first flop feeds only the second
		nxt_st.prog_meta = prog_mode;
		nxt_st.prog_sync = st_ff.prog_meta;

		// capture once after reset release and hold
		if (!st_ff.loaded) begin
			nxt_st.loaded = 1'b1;
			nxt_st.snap0  = st_ff.opt0;
			nxt_st.snap1  = st_ff.opt1;
		end

		// read data registered in setup so it comes from flops
		if (setup) begin
			nxt_st.rdata = '0;
			nxt_st.err   = !known ||
				(opt_addr && !st_ff.prog_sync);
			if (opt_addr && req.pwrite && busy)
				nxt_st.err = 1'b1;
			if (!req.pwrite) begin
				unique case (req.paddr)
				obcd_pkg::OBCD_ADDR_OPT0: begin
					if (st_ff.prog_sync)
						nxt_st.rdata[7:0] = st_ff.opt0;
				end
				obcd_pkg::OBCD_ADDR_OPT1: begin
					if (st_ff.prog_sync)
						nxt_st.rdata[7:0] = st_ff.opt1;
				end
				obcd_pkg::OBCD_ADDR_STATUS: begin
					nxt_st.rdata[obcd_pkg::OBCD_ST_PROG] =
						st_ff.prog_sync;
					nxt_st.rdata[obcd_pkg::OBCD_ST_BUSY] = busy;
					nxt_st.rdata[obcd_pkg::OBCD_ST_DBL_BAD] =
						dec.clock_doubler_bad;
					nxt_st.rdata[obcd_pkg::OBCD_ST_RDP] =
						dec.readout_protect;
					nxt_st.rdata[obcd_pkg::OBCD_ST_LOADED] =
						st_ff.loaded;
				end
				default: begin
					nxt_st.rdata = '0;
				end
				endcase
			end
		end

		// writes take effect at the access edge
		if (access && req.pwrite && !st_ff.err) begin
			if (req.paddr == obcd_pkg::OBCD_ADDR_OPT0)
				nxt_st.opt0 = req.pwdata[7:0];
			if (req.paddr == obcd_pkg::OBCD_ADDR_OPT1)
				nxt_st.opt1 = req.pwdata[7:0];
			if (req.paddr == obcd_pkg::OBCD_ADDR_CTRL &&
				req.pwdata[obcd_pkg::OBCD_CTRL_ERASE] &&
				st_ff.prog_sync && !busy) begin
				// live byte decides: protection as stored now
				if (!st_ff.opt0[obcd_pkg::OBCD_B0_RDP])
					nxt_st.erase = obcd_pkg::OBCD_MEM_ERASE;
				else
					nxt_st.erase = obcd_pkg::OBCD_OPT_ERASE;
			end
		end

		unique case (st_ff.erase)
		obcd_pkg::OBCD_IDLE: begin
		end
		obcd_pkg::OBCD_MEM_ERASE: begin
			if (user_mem_erase_done)
				nxt_st.erase = obcd_pkg::OBCD_OPT_ERASE;
		end
		obcd_pkg::OBCD_OPT_ERASE: begin
			nxt_st.opt0  = obcd_pkg::OBCD_ERASED;
			nxt_st.opt1  = obcd_pkg::OBCD_ERASED;
			nxt_st.erase = obcd_pkg::OBCD_IDLE;
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff.opt0      <= obcd_pkg::OBCD_SHIP_OPT0;
			st_ff.opt1      <= obcd_pkg::OBCD_SHIP_OPT1;
			st_ff.prog_meta <= 1'b0;
			st_ff.prog_sync <= 1'b0;
			st_ff.loaded    <= 1'b0;
			st_ff.snap0     <= obcd_pkg::OBCD_SHIP_OPT0;
			st_ff.snap1     <= obcd_pkg::OBCD_SHIP_OPT1;
			st_ff.erase     <= obcd_pkg::OBCD_IDLE;
			st_ff.rdata     <= 32'h0000_0000;
			st_ff.err       <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// zero wait state slave
	assign pready             = 1'b1;
	assign prdata             = st_ff.rdata;
	assign pslverr            = access && st_ff.err;
	assign user_mem_erase_req = st_ff.erase == obcd_pkg::OBCD_MEM_ERASE;
	assign flash_read_block   = dec.readout_protect;
	assign flash_write_block  = dec.readout_protect;
	assign cfg                = dec;

endmodule // obcd_option_decoder

`default_nettype wire

// [verification/obcd_checker.sv]
// Purpose: port assertions for the option decoder
// Assumes: one pclk domain
// Notes: bound at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module obcd_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic prog_mode,
	input wire logic user_mem_erase_req,
	input wire logic user_mem_erase_done,
	input wire logic flash_read_block,
	input wire logic flash_write_block,
	input wire obcd_pkg::obcd_cfg_t cfg
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_cfg_frozen: assert property ($past(presetn, 3) |-> $stable(cfg))
		else $error("settings moved while running");
	a_vd_detect: assert property (cfg.low_voltage_detector
		== cfg.aux_voltage_detector && cfg.low_voltage_detector
		== (cfg.voltage_detect_level != obcd_pkg::OBCD_VD_OFF))
		else $error("detector enables disagree with level");
	a_rst_len: assert property (cfg.reset_cycle_count inside
		{13'h1000, 13'h0100}) else $error("bad reset phase length");
	a_dbl_legal: assert property (cfg.clock_doubler_en |->
		cfg.osc_range_select == 3'h1 && cfg.osc_source_type != 2'h2)
		else $error("doubler on outside its range");
	a_dbl_flag: assert property (!(cfg.clock_doubler_en
		&& cfg.clock_doubler_bad)) else $error("doubler on and flagged");
	a_block_pair: assert property (flash_read_block == flash_write_block)
		else $error("read and write blocks differ");
	a_opt_closed: assert property (psel && penable && paddr < 8'h08
		&& !prog_mode && !$past(prog_mode) && !$past(prog_mode, 2)
		&& !$past(prog_mode, 3) |-> pslverr && (pwrite || prdata == 0))
		else $error("option byte reachable outside programming");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access cycle");
	a_req_holds: assert property (user_mem_erase_req &&
		!user_mem_erase_done |=> user_mem_erase_req)
		else $error("wipe request dropped early");
	a_req_ends: assert property ($fell(user_mem_erase_req) |->
		$past(user_mem_erase_done)) else $error("wipe request ended alone");
	c_wipe: cover property ($rose(user_mem_erase_req));
	c_dbl: cover property (cfg.clock_doubler_en);
	c_refuse: cover property (pslverr);
	c_prot: cover property (flash_read_block);
endmodule // obcd_checker
bind obcd_option_decoder obcd_checker i_obcd_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.prog_mode(prog_mode), .user_mem_erase_req(user_mem_erase_req),
	.user_mem_erase_done(user_mem_erase_done), .cfg(cfg),
	.flash_read_block(flash_read_block),
	.flash_write_block(flash_write_block));
`default_nettype wire

// [verification/obcd_flash_model.sv]
// Purpose: flash controller answering the user memory wipe
// Assumes: lag of at least 2
// Notes: done is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module obcd_flash_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic user_mem_erase_req,
	input wire logic [3:0] lag,
	output logic user_mem_erase_done
);
	logic [3:0] cnt_ff;
	// wipe runs lag+1 cycles before done, so slow answers get exercised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 4'h0;
			user_mem_erase_done <= 1'b0;
		end else begin
			user_mem_erase_done <= user_mem_erase_req
				&& cnt_ff == lag && !user_mem_erase_done;
			cnt_ff <= (user_mem_erase_req && !user_mem_erase_done)
				? cnt_ff + 4'h1 : 4'h0;
		end
	end
endmodule // obcd_flash_model
`default_nettype wire

// [verification/tb.sv]
// Purpose: self-checking bench of the option decoder
// Assumes: presetn restores the shipped option bytes
// Notes: cfg is compared with a decode model after each reset
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic pclk, presetn, psel, penable, pwrite, prog_mode, pready;
	logic pslverr, req, done, rblk, wblk, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] lag;
	obcd_pkg::obcd_cfg_t cfg;
	int n_fail = 0, comparisons = 0, b0, b1, w0, w1, i;
	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	obcd_option_decoder i_obcd_option_decoder (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prog_mode(prog_mode), .user_mem_erase_req(req),
		.user_mem_erase_done(done), .flash_read_block(rblk),
		.flash_write_block(wblk), .cfg(cfg));
	obcd_flash_model i_obcd_flash_model (.pclk(pclk), .presetn(presetn),
		.user_mem_erase_req(req), .lag(lag), .user_mem_erase_done(done));
	task chk(string n, logic [31:0] s, logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task rst;
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
	endtask
	task apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task chk_cfg;
		logic d, ok;
		d = !b1[0];
		ok = b1[3:1] == 3'h1 && b1[5:4] != 2'h2;
		chk("cfg0", {cfg.halt_watchdog_reset_opt, cfg.watchdog_always_on,
			cfg.low_voltage_detector, cfg.aux_voltage_detector,
			cfg.voltage_detect_level, cfg.readout_protect}, {b0[7],
			!b0[6], {2{b0[4:3] != 2'h3}}, b0[4:3], !b0[0]});
		chk("cfg1", {cfg.reset_cycle_count, cfg.osc_source_type,
			cfg.osc_range_select, cfg.clock_doubler_en,
			cfg.clock_doubler_bad}, {(b1[6] ? 13'h0100 : 13'h1000),
			b1[5:1], d && ok, d && !ok});
		chk("blk", {rblk, wblk}, {2{b0[0] == 0}});
	endtask
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
		pwdata = 0; prog_mode = 0; lag = 4'h3;
		void'($urandom(56106));
		rst;
		b0 = 'hff;
		b1 = 'hef;
		chk_cfg;
		apb(0, 8'h00, 0);
		chk("closed", rd, 0);
		chk("closed_err", err, 1);
		apb(0, 8'h10, 0);
		chk("unmapped_err", err, 1);
		prog_mode <= 1;
		for (i = 0; i < 5; i++) begin
			repeat (3) @(posedge pclk);
			apb(0, 8'h00, 0);
			chk("opt0", rd, b0);
			w0 = $urandom & 'hff | 'h26;
			w1 = i ? $urandom & 'hff : 'h02;
			apb(1, 8'h00, w0);
			apb(1, 8'h04, w1);
			apb(0, 8'h00, 0);
			chk("opt0_wr", rd, w0);
			apb(0, 8'h04, 0);
			chk("opt1", rd, w1);
			chk_cfg;
			rst;
			chk_cfg;
		end
		apb(1, 8'h00, 'he6);
		lag <= 4'(2 + $urandom % 6);
		apb(1, 8'h08, 1);
		repeat (3) @(posedge pclk);
		#1 chk("wipe_req", req, 1);
		while (req) @(posedge pclk);
		repeat (2) @(posedge pclk);
		apb(0, 8'h00, 0);
		chk("erased0", rd, 'hff);
		apb(0, 8'h04, 0);
		chk("erased1", rd, 'hff);
		apb(1, 8'h04, $urandom & 'h7f);
		apb(1, 8'h08, 1);
		@(posedge pclk);
		#1 chk("no_wipe", req, 0);
		apb(0, 8'h04, 0);
		chk("erased1b", rd, 'hff);
		rst;
		chk_cfg;
		apb(0, 8'h0c, 0);
		chk("status", rd, 'h11);
		report_and_stop;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
